//--- rtl/sltc_speed_loop_regs.sv
// Operation
// - speed loop output clamped by limit field
// - positive limit uses sense-gain current scaling
// - negative limit is 2^12 minus magnitude
// - torque command is 12 bits, same scaling
// - negative command read as signed 12-bit
// - current-sense gain coefficient defaults to 2
// - integral term uses integral gain and ratio
// - anti-windup correction weighted by its gain
`timescale 1ns/1ps
`include "sltc_defines.svh"

module sltc_speed_loop_regs #(
   parameter int ERR_W = 16,
   parameter int ACC_W = 48,
   parameter int SENSE_GAIN = `SLTC_SENSE_GAIN_DEFAULT
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register access from the serial link decoder
   input wire sltc_pkg::sltc_req_t regReq,
   output logic [15:0] regRdData,
   output logic regRdValid,
   output logic regAddrError,
   // speed loop
   input wire logic loopTick,
   input wire logic loopEnable,
   input wire logic signed [ERR_W-1:0] speedError,
   output logic signed [11:0] torqueCurrentReference,
   output logic clampActive,
   output logic signed [11:0] torqueCurrentCommand,
   output logic updateDone
);

   if (ERR_W < 2 || ERR_W > 24 || ACC_W < ERR_W + 18 || ACC_W > 56 || SENSE_GAIN < 1) begin : g_chk
      $error("sltc_speed_loop_regs: unsupported parameter values");
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic isMapped(input logic [7:0] a);
      if (a >= `SLTC_OFS_SPEED_PROP_GAIN && a <= `SLTC_OFS_TORQUE_CURRENT_CLAMP) begin
         return 1'b1;
      end else if (a == `SLTC_OFS_TORQUE_CURRENT_COMMAND) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction : isMapped

   // ----------------------------------------
   // register file
   // ----------------------------------------
   sltc_pkg::sltc_gains_t host;
   sltc_pkg::sltc_gains_t next_host;
   logic [15:0] next_regRdData;
   logic next_regRdValid;
   logic next_regAddrError;

   always_comb begin
      next_host = host;
      next_regRdData = 16'h0000;
      next_regRdValid = 1'b0;
      next_regAddrError = 1'b0;
      if (regReq.write) begin
         if (regReq.addr == `SLTC_OFS_SPEED_PROP_GAIN) begin
            next_host.kp = regReq.wdata;
         end else if (regReq.addr == `SLTC_OFS_SPEED_PROP_GAIN_RATIO) begin
            next_host.kpRatio = regReq.wdata;
         end else if (regReq.addr == `SLTC_OFS_SPEED_INTEGRAL_GAIN) begin
            next_host.ki = regReq.wdata;
         end else if (regReq.addr == `SLTC_OFS_SPEED_INTEGRAL_GAIN_RATIO) begin
            next_host.kiRatio = regReq.wdata;
         end else if (regReq.addr == `SLTC_OFS_SPEED_ANTIWINDUP_GAIN) begin
            next_host.kc = regReq.wdata;
         end else if (regReq.addr == `SLTC_OFS_TORQUE_CURRENT_CLAMP) begin
            next_host.clamp = regReq.wdata[`SLTC_CUR_MSB:0];
         end else if (regReq.addr == `SLTC_OFS_TORQUE_CURRENT_COMMAND) begin
            next_host.cmd = regReq.wdata[`SLTC_CUR_MSB:0];
         end
         next_regAddrError = !isMapped(regReq.addr);
      end else if (regReq.read) begin
         next_regRdValid = 1'b1;
         next_regAddrError = !isMapped(regReq.addr);
         if (regReq.addr == `SLTC_OFS_SPEED_PROP_GAIN) begin
            next_regRdData = host.kp;
         end else if (regReq.addr == `SLTC_OFS_SPEED_PROP_GAIN_RATIO) begin
            next_regRdData = host.kpRatio;
         end else if (regReq.addr == `SLTC_OFS_SPEED_INTEGRAL_GAIN) begin
            next_regRdData = host.ki;
         end else if (regReq.addr == `SLTC_OFS_SPEED_INTEGRAL_GAIN_RATIO) begin
            next_regRdData = host.kiRatio;
         end else if (regReq.addr == `SLTC_OFS_SPEED_ANTIWINDUP_GAIN) begin
            next_regRdData = host.kc;
         end else if (regReq.addr == `SLTC_OFS_TORQUE_CURRENT_CLAMP) begin
            next_regRdData = {4'h0, host.clamp};
         end else if (regReq.addr == `SLTC_OFS_TORQUE_CURRENT_COMMAND) begin
            next_regRdData = {4'h0, host.cmd};
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         host.kp <= `SLTC_RST_SPEED_PROP_GAIN;
         host.kpRatio <= `SLTC_RST_SPEED_PROP_GAIN_RATIO;
         host.ki <= `SLTC_RST_SPEED_INTEGRAL_GAIN;
         host.kiRatio <= `SLTC_RST_SPEED_INTEGRAL_GAIN_RATIO;
         host.kc <= `SLTC_RST_SPEED_ANTIWINDUP_GAIN;
         host.clamp <= `SLTC_RST_TORQUE_CURRENT_CLAMP;
         host.cmd <= `SLTC_RST_TORQUE_CURRENT_COMMAND;
         regRdData <= 16'h0000;
         regRdValid <= 1'b0;
         regAddrError <= 1'b0;
      end else begin
         host <= next_host;
         regRdData <= next_regRdData;
         regRdValid <= next_regRdValid;
         regAddrError <= next_regAddrError;
      end
   end

   // ----------------------------------------
   // speed loop datapath
   // ----------------------------------------
   sltc_pkg::sltc_gains_t act;
   logic signed [ACC_W-1:0] integ;
   logic signed [ACC_W-1:0] errExt;
   logic signed [ACC_W-1:0] pTerm;
   logic signed [ACC_W-1:0] iInc;
   logic signed [ACC_W-1:0] unsat;
   logic signed [ACC_W-1:0] satExt;
   logic signed [ACC_W+16:0] awProd;
   logic signed [ACC_W-1:0] awTerm;
   logic signed [11:0] satOut;
   logic satHit;

   // gains take effect from the update after the one that latches them
   always_comb begin
      errExt = ACC_W'(speedError);
      pTerm = (errExt * $signed({1'b0, act.kp}))
         >>> act.kpRatio[`SLTC_RATIO_SHIFT_MSB:`SLTC_RATIO_SHIFT_LSB];
      iInc = (errExt * $signed({1'b0, act.ki}))
         >>> act.kiRatio[`SLTC_RATIO_SHIFT_MSB:`SLTC_RATIO_SHIFT_LSB];
      unsat = pTerm + integ;
      satExt = ACC_W'(satOut);
      awProd = (ACC_W+17)'(satExt - unsat) * $signed({1'b0, act.kc});
      awTerm = ACC_W'(awProd
         >>> act.kiRatio[`SLTC_RATIO_SHIFT_MSB:`SLTC_RATIO_SHIFT_LSB]);
   end

   // clamp code is two's complement in sense-gain scaled units
   sltc_sat #(
      .IN_W(ACC_W),
      .OUT_W(12)
   ) u_sat (
      .value(unsat),
      .limit(act.clamp),
      .clamped(satOut),
      .hit(satHit)
   );

   // ----------------------------------------
   // loop update registers
   // ----------------------------------------
   sltc_pkg::sltc_gains_t next_act;
   logic signed [ACC_W-1:0] next_integ;
   logic signed [11:0] next_torqueCurrentReference;
   logic next_clampActive;
   logic signed [11:0] next_torqueCurrentCommand;
   logic next_updateDone;

   always_comb begin
      next_act = act;
      next_integ = integ;
      next_torqueCurrentReference = torqueCurrentReference;
      next_clampActive = clampActive;
      next_torqueCurrentCommand = torqueCurrentCommand;
      next_updateDone = 1'b0;
      if (loopTick) begin
         next_act = host;
         next_updateDone = 1'b1;
         next_torqueCurrentCommand = $signed(act.cmd);
         if (loopEnable) begin
            next_integ = integ + iInc + awTerm;
            next_torqueCurrentReference = satOut;
            next_clampActive = satHit;
         end else begin
            next_integ = '0;
            next_torqueCurrentReference = 12'sh000;
            next_clampActive = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         act.kp <= `SLTC_RST_SPEED_PROP_GAIN;
         act.kpRatio <= `SLTC_RST_SPEED_PROP_GAIN_RATIO;
         act.ki <= `SLTC_RST_SPEED_INTEGRAL_GAIN;
         act.kiRatio <= `SLTC_RST_SPEED_INTEGRAL_GAIN_RATIO;
         act.kc <= `SLTC_RST_SPEED_ANTIWINDUP_GAIN;
         act.clamp <= `SLTC_RST_TORQUE_CURRENT_CLAMP;
         act.cmd <= `SLTC_RST_TORQUE_CURRENT_COMMAND;
         integ <= '0;
         torqueCurrentReference <= 12'sh000;
         clampActive <= 1'b0;
         torqueCurrentCommand <= 12'sh000;
         updateDone <= 1'b0;
      end else begin
         act <= next_act;
         integ <= next_integ;
         torqueCurrentReference <= next_torqueCurrentReference;
         clampActive <= next_clampActive;
         torqueCurrentCommand <= next_torqueCurrentCommand;
         updateDone <= next_updateDone;
      end
   end

endmodule : sltc_speed_loop_regs

//--- rtl/sltc_defines.svh
`ifndef SLTC_DEFINES_SVH
`define SLTC_DEFINES_SVH

// ----------------------------------------
// register word offsets
// ----------------------------------------
`define SLTC_OFS_SPEED_PROP_GAIN 8'h22
`define SLTC_OFS_SPEED_PROP_GAIN_RATIO 8'h23
`define SLTC_OFS_SPEED_INTEGRAL_GAIN 8'h24
`define SLTC_OFS_SPEED_INTEGRAL_GAIN_RATIO 8'h25
`define SLTC_OFS_SPEED_ANTIWINDUP_GAIN 8'h26
`define SLTC_OFS_TORQUE_CURRENT_CLAMP 8'h27
`define SLTC_OFS_TORQUE_CURRENT_COMMAND 8'h2f

// ----------------------------------------
// reset values
// ----------------------------------------
`define SLTC_RST_SPEED_PROP_GAIN 16'hfde8
`define SLTC_RST_SPEED_PROP_GAIN_RATIO 16'h8009
`define SLTC_RST_SPEED_INTEGRAL_GAIN 16'h0309
`define SLTC_RST_SPEED_INTEGRAL_GAIN_RATIO 16'h8013
`define SLTC_RST_SPEED_ANTIWINDUP_GAIN 16'h0032
`define SLTC_RST_TORQUE_CURRENT_CLAMP 12'h03ff
`define SLTC_RST_TORQUE_CURRENT_COMMAND 12'h000a

// ----------------------------------------
// field layout
// ----------------------------------------
`define SLTC_RATIO_SHIFT_MSB 4
`define SLTC_RATIO_SHIFT_LSB 0
`define SLTC_CUR_MSB 11
`define SLTC_SENSE_GAIN_DEFAULT 2

`endif

//--- rtl/sltc_pkg.sv
package sltc_pkg;

   // host register access, one word per request
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic write;
      logic read;
   } sltc_req_t;

   // gain and current set used by one loop update
   typedef struct packed {
      logic [15:0] kp;
      logic [15:0] kpRatio;
      logic [15:0] ki;
      logic [15:0] kiRatio;
      logic [15:0] kc;
      logic [11:0] clamp;
      logic [11:0] cmd;
   } sltc_gains_t;

endpackage : sltc_pkg

//--- rtl/sltc_sat.sv
`timescale 1ns/1ps

// symmetric clamp of a wide signed value to +/- |limit|
module sltc_sat #(
   parameter int IN_W = 48,
   parameter int OUT_W = 12
) (
   // value and limit
   input wire logic signed [IN_W-1:0] value,
   input wire logic [OUT_W-1:0] limit,
   // result
   output logic signed [OUT_W-1:0] clamped,
   output logic hit
);

   logic signed [IN_W-1:0] mag;
   logic signed [OUT_W-1:0] lim;

   if (IN_W <= OUT_W) begin : g_chk
      $error("sltc_sat: IN_W must exceed OUT_W");
   end

   // limit is two's complement; a negative code clamps to its magnitude
   always_comb begin
      lim = $signed(limit);
      if (lim[OUT_W-1]) begin
         lim = -lim;
      end
      if (lim[OUT_W-1]) begin
         lim = {1'b0, {(OUT_W-1){1'b1}}};
      end
      mag = IN_W'(lim);
      if (value > mag) begin
         clamped = lim;
         hit = 1'b1;
      end else if (value < -mag) begin
         clamped = -lim;
         hit = 1'b1;
      end else begin
         clamped = value[OUT_W-1:0];
         hit = 1'b0;
      end
   end

endmodule : sltc_sat

//--- sim/sltc_host_model.sv
`timescale 1ns/1ps
module sltc_host_model (
   // clock
   input wire logic mclk,
   // register port
   output sltc_pkg::sltc_req_t regReq,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input wire logic regAddrError
);
   initial regReq = '0;

   // host side current coding
   function automatic logic [11:0] encCur(input real iq);
      int mag;
      mag = int'((iq < 0.0 ? -iq : iq) * 1.5 * 0.01 * 2 * 1024 / 1.6);
      return (iq < 0.0) ? 12'(4096 - mag) : 12'(mag);
   endfunction : encCur

   // one word access, released lines show the inverse
   task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data,
                         output logic [15:0] rd, output logic err, output logic vld);
      @(negedge mclk);
      regReq = '{addr, data, wr, !wr};
      @(negedge mclk);
      regReq = '{~addr, ~data, 1'b0, 1'b0};
      rd = regRdData;
      err = regAddrError;
      vld = regRdValid;
   endtask : access
endmodule : sltc_host_model

//--- sim/sltc_properties.sv
`timescale 1ns/1ps
`include "sltc_defines.svh"
module sltc_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire sltc_pkg::sltc_req_t regReq,
   input wire logic [15:0] regRdData,
   input wire logic regRdValid,
   input wire logic regAddrError,
   // loop
   input wire logic loopTick,
   input wire logic loopEnable,
   input wire logic signed [11:0] torqueCurrentReference,
   input wire logic clampActive,
   input wire logic signed [11:0] torqueCurrentCommand,
   input wire logic updateDone
);
   logic [2:0][11:0] limPipe;
   logic [2:0][11:0] cmdPipe;
   logic [2:0][11:0] next_limPipe;
   logic [2:0][11:0] next_cmdPipe;
   logic [11:0] limMag;
   logic [11:0] refMag;

   // host copy, active copy, copy in use
   always_comb begin
      next_limPipe = limPipe;
      next_cmdPipe = cmdPipe;
      if (regReq.write && regReq.addr == `SLTC_OFS_TORQUE_CURRENT_CLAMP) begin
         next_limPipe[0] = regReq.wdata[11:0];
      end
      if (regReq.write && regReq.addr == `SLTC_OFS_TORQUE_CURRENT_COMMAND) begin
         next_cmdPipe[0] = regReq.wdata[11:0];
      end
      if (loopTick) begin
         next_limPipe[2:1] = limPipe[1:0];
         next_cmdPipe[2:1] = cmdPipe[1:0];
      end
   end
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         limPipe <= {3{`SLTC_RST_TORQUE_CURRENT_CLAMP}};
         cmdPipe <= {3{`SLTC_RST_TORQUE_CURRENT_COMMAND}};
      end else begin
         limPipe <= next_limPipe;
         cmdPipe <= next_cmdPipe;
      end
   end
   assign limMag = (limPipe[2] == 12'h800) ? 12'h7ff :
                   limPipe[2][11] ? 12'h000 - limPipe[2] : limPipe[2];
   assign refMag = torqueCurrentReference[11] ? 12'h000 - torqueCurrentReference :
                   torqueCurrentReference;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   chk_ref_limit: assert property (updateDone |-> refMag <= limMag)
      else $error("reference beyond clamp");
   chk_flag_clear: assert property (updateDone && refMag < limMag |-> !clampActive)
      else $error("clamp flag without clamp");
   chk_cmd_value: assert property (updateDone |-> torqueCurrentCommand == cmdPipe[2])
      else $error("command not from register");
   chk_read_masked: assert property (regRdValid && $past(regReq.addr == 8'h27
      || regReq.addr == 8'h2f) |-> regRdData[15:12] == 4'h0)
      else $error("upper bits kept");
   chk_outputs_held: assert property (!$past(loopTick) |-> $stable(torqueCurrentReference)
      && $stable(torqueCurrentCommand))
      else $error("output moved without update");
   chk_update_pulse: assert property (loopTick |=> updateDone)
      else $error("no update done");
   chk_disabled_zero: assert property (loopTick && !loopEnable
      |=> torqueCurrentReference == 0)
      else $error("disabled loop output not zero");
   chk_read_answer: assert property (regReq.read && !regReq.write |=> regRdValid)
      else $error("read not answered");
   cover property (updateDone && clampActive);
   cover property (updateDone && torqueCurrentCommand[11]);
   cover property (regRdValid && regAddrError);
endmodule : sltc_properties

bind sltc_speed_loop_regs sltc_properties u_chk (.mclk, .reset, .regReq, .regRdData,
   .regRdValid, .regAddrError, .loopTick, .loopEnable, .torqueCurrentReference,
   .clampActive, .torqueCurrentCommand, .updateDone);

//--- sim/test_speed_loop_torque_cmd_regs.sv
`timescale 1ns/1ps
module test_speed_loop_torque_cmd_regs;
   logic mclk;
   logic reset;
   sltc_pkg::sltc_req_t regReq;
   logic [15:0] regRdData;
   logic regRdValid;
   logic regAddrError;
   logic loopTick;
   logic loopEnable;
   logic signed [15:0] speedError;
   logic signed [11:0] torqueCurrentReference;
   logic clampActive;
   logic signed [11:0] torqueCurrentCommand;
   logic updateDone;
   int miscompares = 0;
   int samplesChecked = 0;
   logic [7:0] ofs [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2f};
   logic [15:0] rstv [7] = '{16'hfde8, 16'h8009, 16'h0309, 16'h8013, 16'h0032, 16'h03ff, 16'h000a};
   logic signed [15:0] errB [6] = '{16'sd100, 16'sd100, 16'sd100, 16'sd0, -16'sd200, 16'sd0};
   logic [11:0] expB [6] = '{12'h000, 12'h064, 12'h096, 12'h096, 12'h096, 12'hfce};

   sltc_speed_loop_regs DUT (.mclk, .reset, .regReq, .regRdData, .regRdValid, .regAddrError,
      .loopTick, .loopEnable, .speedError, .torqueCurrentReference, .clampActive,
      .torqueCurrentCommand, .updateDone);
   sltc_host_model host (.mclk, .regReq, .regRdData, .regRdValid, .regAddrError);

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : checkVal

   task automatic rw(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] exp, input logic expErr);
      logic [15:0] rd;
      logic e;
      logic v;
      host.access(wr, a, d, rd, e, v);
      checkVal({14'h0, e, v}, {14'h0, expErr, !wr});
      if (!wr) checkVal(rd, exp);
   endtask : rw

   task automatic tick(input logic signed [15:0] err, input logic [11:0] expRef);
      @(negedge mclk);
      loopTick = 1'b1;
      speedError = err;
      @(negedge mclk);
      loopTick = 1'b0;
      checkVal({3'h0, updateDone, torqueCurrentReference}, {4'h1, expRef});
   endtask : tick

   // load gains, two disabled updates, command follows on the second
   task automatic cfg(input logic [15:0] kp, ki, kc, lim, cmd, input logic [11:0] old);
      logic [15:0] v [7];
      v = '{kp, 16'h8000, ki, 16'h8000, kc, lim, cmd};
      for (int i = 0; i < 7; i++) rw(1'b1, ofs[i], v[i], 16'h0000, 1'b0);
      loopEnable = 1'b0;
      tick(16'sd0, 12'h000);
      checkVal({4'h0, torqueCurrentCommand}, {4'h0, old});
      tick(16'sd0, 12'h000);
      checkVal({4'h0, torqueCurrentCommand}, {4'h0, cmd[11:0]});
      loopEnable = 1'b1;
   endtask : cfg

   task automatic completeRun();
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : completeRun

   initial begin
      #1000000;
      miscompares++;
      completeRun();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset = 1'b1;
      loopTick = 1'b0;
      loopEnable = 1'b0;
      speedError = 16'sd0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      for (int i = 0; i < 7; i++) rw(1'b0, ofs[i], 16'h0000, rstv[i], 1'b0);
      for (int i = 0; i < 7; i++) begin
         rw(1'b1, ofs[i], 16'hc3a5, 16'h0000, 1'b0);
         rw(1'b0, ofs[i], 16'h0000, (i < 5) ? 16'hc3a5 : 16'h03a5, 1'b0);
      end
      rw(1'b1, 8'h28, 16'h1234, 16'h0000, 1'b1);
      rw(1'b0, 8'h28, 16'h0000, 16'h0000, 1'b1);
      cfg(16'h0100, 16'h0000, 16'h0000, {4'hf, host.encCur(5.0)},
          {4'h5, host.encCur(5.0)}, 12'h00a);
      tick(16'sd1000, host.encCur(5.0));
      checkVal({15'h0, clampActive}, 16'h0001);
      tick(-16'sd1000, host.encCur(-5.0));
      cfg(16'h0100, 16'h0000, 16'h0000, {4'h0, host.encCur(-5.0)},
          {4'h0, host.encCur(-2.5)}, host.encCur(5.0));
      tick(16'sd1000, host.encCur(5.0));
      cfg(16'h0000, 16'h0001, 16'h0001, 16'h0096, 16'h0000, host.encCur(-2.5));
      for (int i = 0; i < 6; i++) tick(errB[i], expB[i]);
      checkVal({15'h0, clampActive}, 16'h0000);
      completeRun();
   end
endmodule : test_speed_loop_torque_cmd_regs
